// >>> rtl/saoc_defs.svh
// constants for the shunt amplifier overcurrent and auto-zero controller
`ifndef SAOC_DEFS_SVH
`define SAOC_DEFS_SVH
// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define SAOC_ADDR_CFG 8'h00
`define SAOC_ADDR_CTRL 8'h04
`define SAOC_ADDR_STAT 8'h08
`define SAOC_ADDR_CNT 8'h0C
// ----------------------------------------
// configuration word fields
// ----------------------------------------
`define SAOC_CFG_TRIG_LSB 0
`define SAOC_CFG_LATCH_BIT 2
`define SAOC_CFG_TRUNC_BIT 3
`define SAOC_CFG_GAIN_LSB 4
`define SAOC_CFG_GAINR_BIT 7
`define SAOC_CFG_DCCAL_BIT 8
`define SAOC_CFG_AZDIS_BIT 9
`define SAOC_CFG_AZSEL_LSB 10
`define SAOC_CFG_SINGLE_INPUT_PWM_MODE_BIT 12
`define SAOC_CFG_ALTREC_BIT 13
`define SAOC_CFG_BLANK_LSB 16
`define SAOC_CFG_RESET 32'h0000_0000
`define SAOC_CTRL_CLEAR_BIT 0
// ----------------------------------------
// status word fields
// ----------------------------------------
`define SAOC_ST_FAULT_BIT 0
`define SAOC_ST_SEEN_BIT 1
`define SAOC_ST_AZ_BIT 2
`define SAOC_ST_GAIN_LSB 4
`define SAOC_ST_TRUNC_BIT 7
// ----------------------------------------
// counts and times
// ----------------------------------------
`define SAOC_QUIET_PERIODS 3
`define SAOC_TARGET_A 8
`define SAOC_TARGET_B 16
`define SAOC_CLK_MHZ 40
`define SAOC_AZ_GAP_US 100
`define SAOC_AZ_NORM_US 200
`define SAOC_AZ_CAL_US 100
`define SAOC_AZ_LEN_US 2
`define SAOC_AZ_GAP_CYC (`SAOC_AZ_GAP_US * `SAOC_CLK_MHZ)
`define SAOC_AZ_NORM_CYC (`SAOC_AZ_NORM_US * `SAOC_CLK_MHZ)
`define SAOC_AZ_CAL_CYC (`SAOC_AZ_CAL_US * `SAOC_CLK_MHZ)
`define SAOC_AZ_LEN_CYC (`SAOC_AZ_LEN_US * `SAOC_CLK_MHZ)
`endif

// >>> rtl/saoc_pkg.sv
// types for the shunt amplifier overcurrent and auto-zero controller
package saoc_pkg;
  typedef enum logic [1:0] {
    SAOC_TRIG_NONE = 2'h0,
    SAOC_TRIG_EVERY = 2'h1,
    SAOC_TRIG_8 = 2'h2,
    SAOC_TRIG_16 = 2'h3
  } saoc_trig_t;
  typedef enum logic [1:0] {
    SAOC_AZ_OFF = 2'b00,
    SAOC_AZ_STARTUP = 2'b01,
    SAOC_AZ_WAIT = 2'b11,
    SAOC_AZ_RUN = 2'b10
  } saoc_az_t;
endpackage : saoc_pkg

// >>> rtl/saoc_az_if.sv
// auto-zero request and status between top and scheduler
`timescale 1ns/1ps
interface saoc_az_if;
  logic enable;
  logic cal_mode;
  logic startup;
  logic standby;
  logic [1:0] phase_sel;
  logic running;
  modport ctl(output enable, output cal_mode, output startup, output standby,
    output phase_sel, input running);
  modport sched(input enable, input cal_mode, input startup, input standby,
    input phase_sel, output running);
endinterface : saoc_az_if

// >>> rtl/saoc_az_sched.sv
// auto-zero scheduler: sync to high side rise, forced interval, start-up
`timescale 1ns/1ps
`include "saoc_defs.svh"
module saoc_az_sched #(
  parameter int GAP_CYC = `SAOC_AZ_GAP_CYC,
  parameter int NORM_CYC = `SAOC_AZ_NORM_CYC,
  parameter int CAL_CYC = `SAOC_AZ_CAL_CYC,
  parameter int LEN_CYC = `SAOC_AZ_LEN_CYC
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [2:0] hs_rise_in,
  saoc_az_if.sched az
);
  saoc_pkg::saoc_az_t state;
  logic [15:0] timer;
  logic [15:0] limit;
  logic rise_sel;
  always_comb begin
    rise_sel = hs_rise_in[az.phase_sel > 2'd2 ? 2'd0 : az.phase_sel];
    limit = az.cal_mode ? 16'(CAL_CYC) : 16'(NORM_CYC);
  end
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state <= saoc_pkg::SAOC_AZ_OFF;
      timer <= 16'h0000;
    end else if (!az.enable) begin
      state <= saoc_pkg::SAOC_AZ_OFF;
      timer <= 16'h0000;
    end else begin
      case (state)
        saoc_pkg::SAOC_AZ_OFF: begin
          state <= az.startup ? saoc_pkg::SAOC_AZ_STARTUP : saoc_pkg::SAOC_AZ_RUN;
          timer <= 16'h0000;
        end
        saoc_pkg::SAOC_AZ_STARTUP: begin
          if (!az.startup) begin
            state <= saoc_pkg::SAOC_AZ_WAIT;
            timer <= 16'h0000;
          end
        end
        saoc_pkg::SAOC_AZ_WAIT: begin
          timer <= timer + 16'h0001;
          // standby has no gate edges, so it runs on the interval alone
          if (az.startup ||
              (timer >= 16'(GAP_CYC) && rise_sel && !az.standby && !az.cal_mode) ||
              timer >= limit) begin
            state <= az.startup ? saoc_pkg::SAOC_AZ_STARTUP : saoc_pkg::SAOC_AZ_RUN;
            timer <= 16'h0000;
          end
        end
        saoc_pkg::SAOC_AZ_RUN: begin
          timer <= timer + 16'h0001;
          if (timer >= 16'(LEN_CYC - 1)) begin
            state <= saoc_pkg::SAOC_AZ_WAIT;
            timer <= 16'h0000;
          end
        end
        default: state <= saoc_pkg::SAOC_AZ_OFF;
      endcase
    end
  end
  assign az.running = az.enable &&
    (state == saoc_pkg::SAOC_AZ_RUN || state == saoc_pkg::SAOC_AZ_STARTUP);
endmodule : saoc_az_sched

// >>> rtl/saoc_blank.sv
// per-phase blanking timer started on each high side edge
`timescale 1ns/1ps
module saoc_blank (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic edge_in,
  input wire logic [7:0] blank_len_in,
  output logic active_out
);
  logic [7:0] cnt;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      cnt <= 8'h00;
    end else if (edge_in) begin
      cnt <= blank_len_in;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign active_out = edge_in || (cnt != 8'h00);
endmodule : saoc_blank

// >>> rtl/saoc_ctrl.sv
// overcurrent counting, fault latching, truncation, gain, dc cal, auto-zero
//
// What this block does
// - one overcurrent event counter per phase, bumped on that phase's event
// - trigger setting: no fault, every event, after 8, or after 16 events
// - fault and low fault_out_n once any counter reaches the target
// - counter clears after 3 quiet pwm cycles before reaching the target
// - latched counting mode: clear ignored until one whole fault-free pwm period
// - latched immediate mode: clear accepted only once overcurrent is gone
// - non-latched: clear any time, fault sets again if condition remains
// - status always records that an overcurrent fault happened
// - truncation forces all high side gates low until next pwm reset
// - single-input alternate recirculation truncates the recirculating side's opposite
// - any amplifier's event truncates all three phases
// - truncation triggers blanked after any high side edge, phases ORed
// - with truncation on, fault_out_n just shows a truncation occurred
// - gain_code 0..7 selects gains 4,8,12,16,20,24,32,64
// - gain_from_resistor uses the resistor step sampled once at start-up
// - dc_cal_enable shorts amplifier inputs while active with driver_enable high
// - auto-zero every 100 us during dc calibration instead of 200 us
// - auto-zero shorts inputs and holds amp_output; autozero_disable suppresses it
// - internal sync: start on first selected gate rise 100 us after last
// - auto-zero runs during charge pump start-up before active state
// - forced auto-zero when no gate rise within the force interval
// - auto-zero keeps running in standby
`timescale 1ns/1ps
`include "saoc_defs.svh"
module saoc_ctrl #(
  parameter int BLANK_W = 8,
  parameter int AZ_GAP_CYC = `SAOC_AZ_GAP_CYC,
  parameter int AZ_NORM_CYC = `SAOC_AZ_NORM_CYC,
  parameter int AZ_CAL_CYC = `SAOC_AZ_CAL_CYC,
  parameter int AZ_LEN_CYC = `SAOC_AZ_LEN_CYC
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [2:0] ocp_in,
  input wire logic [2:0] pwm_hs_in,
  input wire logic [2:0] pwm_ls_in,
  input wire logic pwm_reset_in,
  input wire logic driver_enable_in,
  input wire logic cp_uv_ok_in,
  input wire logic standby_in,
  input wire logic [2:0] resistor_step_in,
  input wire logic hs_recirc_in,
  output logic [2:0] high_side_gate_out,
  output logic [2:0] low_side_gate_out,
  output logic fault_out_n,
  output logic amp_short_out,
  output logic amp_hold_out,
  output logic [6:0] amp_gain_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [13:0] sync1;
  logic [13:0] sync2;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
    end else begin
      sync1 <= {ocp_in, pwm_hs_in, pwm_ls_in, pwm_reset_in, driver_enable_in,
        cp_uv_ok_in, standby_in, hs_recirc_in};
      sync2 <= sync1;
    end
  end
  logic [2:0] ocp;
  logic [2:0] hs;
  logic [2:0] ls;
  logic pwm_rst;
  logic drv_en;
  logic cp_ok;
  logic stby;
  logic hs_recirc;
  assign {ocp, hs, ls, pwm_rst, drv_en, cp_ok, stby, hs_recirc} = sync2;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] cfg;
  logic [2:0] res_step;
  logic res_taken;
  saoc_pkg::saoc_trig_t trig;
  assign trig = saoc_pkg::saoc_trig_t'(cfg[`SAOC_CFG_TRIG_LSB +: 2]);
  wire latch_en = cfg[`SAOC_CFG_LATCH_BIT];
  wire trunc_en = cfg[`SAOC_CFG_TRUNC_BIT];
  wire gain_res = cfg[`SAOC_CFG_GAINR_BIT];
  wire dc_cal = cfg[`SAOC_CFG_DCCAL_BIT];
  wire autozero_disable = cfg[`SAOC_CFG_AZDIS_BIT];
  wire alt_mode = cfg[`SAOC_CFG_SINGLE_INPUT_PWM_MODE_BIT] & cfg[`SAOC_CFG_ALTREC_BIT];
  wire clear_req = wr_in && addr_in == `SAOC_ADDR_CTRL && wdata_in[`SAOC_CTRL_CLEAR_BIT];
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      cfg <= `SAOC_CFG_RESET;
    end else if (wr_in && addr_in == `SAOC_ADDR_CFG) begin
      cfg <= wdata_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      res_step <= 3'h0;
      res_taken <= 1'b0;
    end else if (!res_taken) begin
      res_step <= resistor_step_in;
      res_taken <= 1'b1;
    end
  end
  function automatic logic [6:0] gain_of(input logic [2:0] code);
    case (code)
      3'h0: gain_of = 7'd4;
      3'h1: gain_of = 7'd8;
      3'h2: gain_of = 7'd12;
      3'h3: gain_of = 7'd16;
      3'h4: gain_of = 7'd20;
      3'h5: gain_of = 7'd24;
      3'h6: gain_of = 7'd32;
      default: gain_of = 7'd64;
    endcase
  endfunction : gain_of
  wire [2:0] gain_step = gain_res ? res_step : cfg[`SAOC_CFG_GAIN_LSB +: 3];
  // ----------------------------------------
  // blanking and edges
  // ----------------------------------------
  logic [2:0] hs_q;
  logic [2:0] blank;
  logic [2:0] hs_rise;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      hs_q <= 3'h0;
    end else begin
      hs_q <= hs;
    end
  end
  assign hs_rise = hs & ~hs_q;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_blank
      saoc_blank u_blank (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .edge_in(hs[gi] ^ hs_q[gi]),
        .blank_len_in(cfg[`SAOC_CFG_BLANK_LSB +: 8]),
        .active_out(blank[gi])
      );
    end
  endgenerate
  // blanking ORed over phases; any amplifier
  wire trunc_trig = trunc_en && |ocp && !(|blank);
  // ----------------------------------------
  // event counters
  // ----------------------------------------
  logic [4:0] cnt [3];
  logic [1:0] quiet [3];
  logic [2:0] seen;
  wire [4:0] target = (trig == saoc_pkg::SAOC_TRIG_16) ? 5'(`SAOC_TARGET_B) :
    (trig == saoc_pkg::SAOC_TRIG_8) ? 5'(`SAOC_TARGET_A) : 5'd1;
  logic [2:0] hit;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
          cnt[gi] <= 5'd0;
          quiet[gi] <= 2'd0;
          seen[gi] <= 1'b0;
        end else begin
          if (ocp[gi] && !seen[gi]) begin
            seen[gi] <= 1'b1;
            if (cnt[gi] < target) begin
              cnt[gi] <= cnt[gi] + 5'd1;
            end
          end
          if (pwm_rst) begin
            seen[gi] <= 1'b0;
            if (cnt[gi] >= target) begin
              cnt[gi] <= 5'd0;
              quiet[gi] <= 2'd0;
            end else if (seen[gi] || ocp[gi]) begin
              quiet[gi] <= 2'd0;
            end else if (quiet[gi] == 2'(`SAOC_QUIET_PERIODS - 1)) begin
              quiet[gi] <= 2'd0;
              cnt[gi] <= 5'd0;
            end else begin
              quiet[gi] <= quiet[gi] + 2'd1;
            end
          end
        end
      end
      assign hit[gi] = cnt[gi] >= target;
    end
  endgenerate
  // ----------------------------------------
  // fault latch and clear
  // ----------------------------------------
  logic fault;
  logic fault_seen;
  logic trunc_seen;
  logic clean_period;
  logic period_ok;
  wire counting = trig == saoc_pkg::SAOC_TRIG_8 || trig == saoc_pkg::SAOC_TRIG_16;
  // truncation bypasses deglitch: fault marks truncation
  wire fault_set = (trig != saoc_pkg::SAOC_TRIG_NONE) &&
    (trunc_en ? trunc_trig : (counting ? |hit : |ocp));
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      clean_period <= 1'b1;
      period_ok <= 1'b0;
    end else if (pwm_rst) begin
      period_ok <= clean_period && !(|ocp);
      clean_period <= 1'b1;
    end else if (|ocp) begin
      clean_period <= 1'b0;
      period_ok <= 1'b0;
    end
  end
  wire clear_ok = !latch_en || (counting ? period_ok : !(|ocp));
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      fault <= 1'b0;
    end else if (fault_set) begin
      fault <= 1'b1;
    end else if (clear_req && clear_ok) begin
      fault <= 1'b0;
    end
  end
  // sticky records: fault_seen cleared by the same accepted clear, trunc_seen by any clear request
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      fault_seen <= 1'b0;
      trunc_seen <= 1'b0;
    end else begin
      if (fault_set) begin
        fault_seen <= 1'b1;
      end else if (clear_req && clear_ok) begin
        fault_seen <= 1'b0;
      end
      if (trunc_trig) begin
        trunc_seen <= 1'b1;
      end else if (clear_req) begin
        trunc_seen <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // truncation of gate outputs
  // ----------------------------------------
  logic trunc_hold;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      trunc_hold <= 1'b0;
    end else if (pwm_rst) begin
      trunc_hold <= 1'b0;
    end else if (trunc_trig) begin
      trunc_hold <= 1'b1;
    end
  end
  wire cut = trunc_hold || trunc_trig;
  wire cut_ls = cut && alt_mode && hs_recirc;
  wire cut_hs = cut && !(alt_mode && hs_recirc);
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      high_side_gate_out <= 3'h0;
      low_side_gate_out <= 3'h0;
    end else begin
      high_side_gate_out <= cut_hs ? 3'h0 : hs;
      low_side_gate_out <= cut_ls ? 3'h0 : ls;
    end
  end
  // ----------------------------------------
  // auto-zero and amplifier control
  // ----------------------------------------
  saoc_az_if az_bus ();
  assign az_bus.enable = !autozero_disable && (drv_en || stby);
  assign az_bus.cal_mode = dc_cal && drv_en && cp_ok;
  assign az_bus.startup = drv_en && !cp_ok;
  assign az_bus.standby = stby;
  assign az_bus.phase_sel = cfg[`SAOC_CFG_AZSEL_LSB +: 2];
  saoc_az_sched #(
    .GAP_CYC(AZ_GAP_CYC),
    .NORM_CYC(AZ_NORM_CYC),
    .CAL_CYC(AZ_CAL_CYC),
    .LEN_CYC(AZ_LEN_CYC)
  ) u_az (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .hs_rise_in(hs_rise),
    .az(az_bus.sched)
  );
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      amp_short_out <= 1'b0;
      amp_hold_out <= 1'b0;
      amp_gain_out <= 7'd4;
      fault_out_n <= 1'b1;
    end else begin
      amp_short_out <= az_bus.running || (dc_cal && drv_en && cp_ok);
      amp_hold_out <= az_bus.running;
      amp_gain_out <= gain_of(gain_step);
      fault_out_n <= !(fault || fault_set);
    end
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        `SAOC_ADDR_CFG: rdata_out <= cfg;
        `SAOC_ADDR_STAT: rdata_out <= {24'h00_0000, trunc_seen, gain_step, 1'b0,
          az_bus.running, fault_seen, fault};
        `SAOC_ADDR_CNT: rdata_out <= {17'h0_0000, cnt[2], cnt[1], cnt[0]};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fault_pin;
    @(posedge clock_in) disable iff (!nrst_in) fault_set |=> !fault_out_n;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");
  property p_trunc_hs;
    @(posedge clock_in) disable iff (!nrst_in)
      (trunc_trig && !alt_mode) |=> high_side_gate_out == 3'h0;
  endproperty
  a_trunc_hs: assert property (p_trunc_hs) else $error("high side not cut");
  property p_blank;
    @(posedge clock_in) disable iff (!nrst_in) (|blank) |-> !trunc_trig;
  endproperty
  a_blank: assert property (p_blank) else $error("trunc in blank");
  property p_seen;
    @(posedge clock_in) disable iff (!nrst_in) fault_set |=> fault_seen;
  endproperty
  a_seen: assert property (p_seen) else $error("fault not recorded");
  property p_latch_imm;
    @(posedge clock_in) disable iff (!nrst_in)
      (fault && latch_en && !counting && |ocp && clear_req) |=> fault;
  endproperty
  a_latch_imm: assert property (p_latch_imm) else $error("early clear");
  property p_latch_cnt;
    @(posedge clock_in) disable iff (!nrst_in)
      (fault && latch_en && counting && !period_ok && clear_req) |=> fault;
  endproperty
  a_latch_cnt: assert property (p_latch_cnt) else $error("early count clear");
  property p_gain;
    @(posedge clock_in) disable iff (!nrst_in)
      (!gain_res && cfg[`SAOC_CFG_GAIN_LSB +: 3] == 3'h7) ##1 $stable(cfg) |-> amp_gain_out == 7'd64;
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  property p_azdis;
    @(posedge clock_in) disable iff (!nrst_in) autozero_disable |=> !amp_hold_out;
  endproperty
  a_azdis: assert property (p_azdis) else $error("auto-zero while disabled");
endmodule : saoc_ctrl

// >>> sim/saoc_host_model.sv
// host-side pwm source driving the controller's pwm inputs
`timescale 1ns/1ps
module saoc_host_model #(
  parameter int PERIOD = 32
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic run_in,
  output logic [2:0] pwm_hs_out,
  output logic [2:0] pwm_ls_out,
  output logic pwm_reset_out
);
  logic [7:0] cnt;
  // ----------------------------------------
  // pwm period
  // ----------------------------------------
  // high side in 4..19, low side in 22..29; gap keeps edges apart
  always_ff @(posedge clock_in) begin
    if (!nrst_in || !run_in) begin
      cnt <= 8'h00;
      pwm_hs_out <= 3'h0;
      pwm_ls_out <= 3'h0;
      pwm_reset_out <= 1'b0;
    end else begin
      cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      pwm_reset_out <= (cnt == 8'h00);
      pwm_hs_out <= {3{cnt >= 8'h04 && cnt < 8'h14}};
      pwm_ls_out <= {3{cnt >= 8'h16 && cnt < 8'h1E}};
    end
  end
endmodule : saoc_host_model

// >>> sim/saoc_ctrl_tb.sv
// self-checking bench for the overcurrent and auto-zero controller
`timescale 1ns/1ps
`include "saoc_defs.svh"
module saoc_ctrl_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic [2:0] ocp = 3'h0;
  logic [2:0] hs, ls, hs_g, ls_g, rstep = 3'h5;
  logic prst, flt_n, short, hold;
  logic run = 1'b1;
  logic drv_en = 1'b0;
  logic cp_ok = 1'b0;
  logic stby = 1'b0;
  logic recirc = 1'b0;
  logic [6:0] gain;
  logic [31:0] d;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int g, t;
  logic [6:0] gtab [8] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h40};
  always #12.5 clk = ~clk;
  // short auto-zero timing keeps the run brief
  saoc_ctrl #(.AZ_GAP_CYC(40), .AZ_NORM_CYC(80), .AZ_CAL_CYC(40), .AZ_LEN_CYC(4)) u_dut (
    .clock_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
    .rd_in(rd_s), .rdata_out(rdata), .ocp_in(ocp), .pwm_hs_in(hs), .pwm_ls_in(ls),
    .pwm_reset_in(prst), .driver_enable_in(drv_en), .cp_uv_ok_in(cp_ok),
    .standby_in(stby), .resistor_step_in(rstep), .hs_recirc_in(recirc),
    .high_side_gate_out(hs_g), .low_side_gate_out(ls_g), .fault_out_n(flt_n),
    .amp_short_out(short), .amp_hold_out(hold), .amp_gain_out(gain));
  saoc_host_model #(.PERIOD(32)) u_host (.clock_in(clk), .nrst_in(nrst), .run_in(run),
    .pwm_hs_out(hs), .pwm_ls_out(ls), .pwm_reset_out(prst));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      results;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rchk
  task automatic at(input int n);
    int k;
    @(posedge clk);
    #1;
    for (k = 0; k < 64 && prst !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    repeat (n) @(posedge clk);
    #1;
  endtask : at
  // one 20-cycle event per pwm period, comparator chattering inside each
  task automatic ev(input logic [2:0] m, input int n);
    int i;
    repeat (n) begin
      at(2);
      ocp <= m;
      for (i = 0; i < 20; i++) begin
        @(posedge clk);
        if (i % 6 == 3) ocp <= 3'h0;
        else if (i % 6 == 5) ocp <= m;
      end
      ocp <= 3'h0;
    end
  endtask : ev
  task automatic hw(input logic v);
    int k;
    for (k = 0; k < 300 && hold !== v; k++) begin
      @(posedge clk);
      #1;
    end
  endtask : hw
  task automatic azgap(output int n);
    hw(1'b1);
    hw(1'b0);
    for (n = 0; n < 300 && hold !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : azgap
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rstep <= 3'h2;
    drv_en <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(short), 32'h1);
    cp_ok <= 1'b1;
    repeat (20) @(posedge clk);
    rchk(`SAOC_ADDR_CFG, 32'hFFFF_FFFF, `SAOC_CFG_RESET);
    rchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`SAOC_ADDR_CFG, 32'h0000_0090);
    repeat (4) @(posedge clk);
    chk(32'(gain), 32'h0000_0018);
    rchk(`SAOC_ADDR_STAT, 32'h0000_0070, 32'h0000_0050);
    for (t = 0; t < 8; t++) begin
      wr(`SAOC_ADDR_CFG, 32'(t) << 4);
      repeat (4) @(posedge clk);
      chk(32'(gain), 32'(gtab[t]));
      rchk(`SAOC_ADDR_STAT, 32'h0000_0070, 32'(t) << 4);
    end
    // trigger setting none: a live trip must leave the fault pin high
    ocp <= 3'h1;
    repeat (40) @(posedge clk);
    chk(32'(flt_n), 32'h1);
    // every-event mode, non-latched then latched
    for (t = 0; t < 2; t++) begin
      do_reset;
      wr(`SAOC_ADDR_CFG, (t == 1) ? 32'h0000_0005 : 32'h0000_0001);
      ocp <= 3'h1;
      repeat (40) @(posedge clk);
      chk(32'(flt_n), 32'h0);
      rchk(`SAOC_ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
      wr(`SAOC_ADDR_CTRL, 32'h0000_0001);
      repeat (40) @(posedge clk);
      chk(32'(flt_n), 32'h0);
      ocp <= 3'h0;
      repeat (40) @(posedge clk);
      wr(`SAOC_ADDR_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk(32'(flt_n), 32'h1);
    end
    // counting mode, target 8 then 16, latched
    for (t = 0; t < 2; t++) begin
      do_reset;
      wr(`SAOC_ADDR_CFG, 32'h0000_0006 | 32'(t));
      ev(3'h2, 2);
      at(10);
      rchk(`SAOC_ADDR_CNT, 32'h0000_7FFF, 32'h0000_0040);
      at(10);
      at(10);
      rchk(`SAOC_ADDR_CNT, 32'h0000_7FFF, 32'h0000_0040);
      at(10);
      rchk(`SAOC_ADDR_CNT, 32'h0000_7FFF, 32'h0000_0000);
      ev(3'h4, (8 << t) - 1);
      chk(32'(flt_n), 32'h1);
      ev(3'h4, 1);
      repeat (4) @(posedge clk);
      chk(32'(flt_n), 32'h0);
      wr(`SAOC_ADDR_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk(32'(flt_n), 32'h0);
      at(2);
      at(2);
      wr(`SAOC_ADDR_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk(32'(flt_n), 32'h1);
    end
    // truncation: blank off, long blank, then alternate recirculation
    for (t = 0; t < 3; t++) begin
      do_reset;
      recirc <= (t == 2);
      wr(`SAOC_ADDR_CFG, (t == 1) ? 32'h00FF_0009 : ((t == 2) ? 32'h0000_3009 : 32'h0000_0009));
      at(8);
      ocp <= 3'h1;
      repeat (8) @(posedge clk);
      chk(32'(hs_g), (t == 0) ? 32'h0 : 32'h7);
      repeat (10) @(posedge clk);
      chk(32'(ls_g), (t == 2) ? 32'h0 : 32'h7);
      ocp <= 3'h0;
      if (t == 0) begin
        chk(32'(flt_n), 32'h0);
        rchk(`SAOC_ADDR_STAT, 32'h0000_0080, 32'h0000_0080);
        at(2);
        at(14);
        chk(32'(hs_g), 32'h7);
      end
    end
    // auto-zero scheduling
    do_reset;
    azgap(g);
    chk(32'(g >= 36 && g <= 80), 32'h1);
    hw(1'b1);
    chk(32'(short), 32'h1);
    wr(`SAOC_ADDR_CFG, 32'h0000_0200);
    azgap(g);
    chk(32'(g), 32'h0000_012C);
    run <= 1'b0;
    wr(`SAOC_ADDR_CFG, 32'h0000_0000);
    azgap(g);
    chk(32'(g >= 70 && g <= 90), 32'h1);
    wr(`SAOC_ADDR_CFG, 32'h0000_0100);
    azgap(g);
    chk(32'(g >= 30 && g <= 50), 32'h1);
    hw(1'b0);
    chk(32'(short), 32'h1);
    wr(`SAOC_ADDR_CFG, 32'h0000_0000);
    hw(1'b1);
    hw(1'b0);
    chk(32'(short), 32'h0);
    stby <= 1'b1;
    drv_en <= 1'b0;
    azgap(g);
    chk(32'(g >= 70 && g <= 90), 32'h1);
    results;
  end
endmodule : saoc_ctrl_tb
